// >>> design/addr_map_pkg.sv
// Constants, types and shared decode helpers of the system address decoder.
// Assumes nothing of its users beyond importing the whole package.
package addr_map_pkg;
    // Register port byte offsets
    localparam logic [7:0] REG_ATTR = 8'h00;
    localparam logic [7:0] REG_HOLE = 8'h04;
    localparam logic [7:0] REG_CEIL = 8'h08;
    localparam logic [7:0] REG_MGMT = 8'h0C;
    localparam logic [7:0] REG_LAST = 8'h10;
    // Segment attribute field layout, two bits per segment
    localparam int EXP_BASE_BIT = 0;
    localparam int EXT_BASE_BIT = 16;
    localparam int SYS_BASE_BIT = 24;
    localparam int ATTR_RD = 0;
    localparam int ATTR_WR = 1;
    localparam logic [31:0] ATTR_WMASK = 32'h03FF_FFFF;
    localparam logic [31:0] ATTR_RESET = 32'h0000_0000;
    localparam int HOLE_BIT = 0;
    localparam int MGMT_EN_BIT = 0;
    localparam int MGMT_OPEN_BIT = 1;
    localparam logic [11:0] CEIL_RESET = 12'h010;
    // Host I/O ports of the configuration mechanism
    localparam logic [15:0] IO_CFG_ADDR = 16'h0CF8;
    localparam logic [15:0] IO_CFG_DATA = 16'h0CFC;
    localparam int CFG_EN_BIT = 31;
    localparam logic [31:0] CFG_WMASK = 32'h80FF_FFFC;
    // Memory map boundaries
    localparam logic [31:0] DOS_TOP = 32'h0008_0000;
    localparam logic [31:0] HOLE_TOP = 32'h000A_0000;
    localparam logic [31:0] VIDEO_TOP = 32'h000C_0000;
    localparam logic [31:0] EXP_TOP = 32'h000E_0000;
    localparam logic [31:0] EXT_TOP = 32'h000F_0000;
    localparam logic [31:0] MEG = 32'h0010_0000;
    localparam logic [31:0] INTC_BASE = 32'hFEC0_0000;
    localparam logic [31:0] INTC_TOP = 32'hFEC1_0000;
    localparam logic [31:0] HIBIOS_BASE = 32'hFFE0_0000;

    typedef enum logic [3:0] {
        RG_DOS, RG_HOLE, RG_VIDEO, RG_EXP, RG_EXT, RG_SYS, RG_MAIN,
        RG_PCI, RG_INTC, RG_HIBIOS, RG_ABOVE, RG_IO
    } region_t;

    // Read/write attribute pair of the segment holding a (zero outside)
    function automatic logic [1:0] seg_attr(input logic [31:0] attr,
                                            input logic [31:0] a);
        logic [1:0] r;
        r = 2'b00;
        if (a[31:17] == 15'h0006) begin
            r = attr[EXP_BASE_BIT + 2 * a[16:14] +: 2];
        end else if (a[31:16] == 16'h000E) begin
            r = attr[EXT_BASE_BIT + 2 * a[15:14] +: 2];
        end else if (a[31:16] == 16'h000F) begin
            r = attr[SYS_BASE_BIT +: 2];
        end
        return r;
    endfunction
endpackage

// >>> design/map_if.sv
// One decode request and its routing answer between the top and a decoder.
// Assumes the requester drives every request field combinationally.
`timescale 1ns/1ps
interface map_if;
    import addr_map_pkg::*;
    logic [31:0] addr;
    logic hi;
    logic io;
    logic write;
    logic mgmt;
    logic from_pci;
    logic [31:0] attr;
    logic hole;
    logic mgmt_en;
    logic mgmt_open;
    logic cfg_en;
    logic [11:0] ceil;
    region_t region;
    logic to_dram;
    logic to_pci;
    logic absorb;
    logic internal;
    logic cfg;
    modport requester(output addr, hi, io, write, mgmt, from_pci, attr, hole,
                      mgmt_en, mgmt_open, cfg_en, ceil,
                      input region, to_dram, to_pci, absorb, internal, cfg);
    modport decoder(input addr, hi, io, write, mgmt, from_pci, attr, hole,
                    mgmt_en, mgmt_open, cfg_en, ceil,
                    output region, to_dram, to_pci, absorb, internal, cfg);
endinterface

// >>> design/addr_decode.sv
// Combinational routing of one host or PCI-initiated access.
// Assumes the requester registers the answer; nothing here is clocked.
`timescale 1ns/1ps
module addr_decode
    import addr_map_pkg::*;
(
    map_if.decoder m
);
    logic [1:0] sa;
    logic en;

    always_comb begin
        sa = seg_attr(m.attr, m.addr);
        en = m.write ? sa[ATTR_WR] : sa[ATTR_RD];
        m.region = RG_IO;
        m.to_dram = 1'b0;
        m.to_pci = 1'b0;
        m.absorb = 1'b0;
        m.internal = 1'b0;
        m.cfg = 1'b0;
        if (m.io) begin
            // PCI-side I/O is never claimed here
            if (m.from_pci) begin
                m.region = RG_IO;
            end else if (m.addr[15:2] == IO_CFG_ADDR[15:2]) begin
                m.internal = 1'b1;
            end else if (m.addr[15:2] == IO_CFG_DATA[15:2] && m.cfg_en) begin
                m.cfg = 1'b1;
                m.to_pci = 1'b1;
            end else begin
                m.to_pci = 1'b1;
            end
        end else if (m.hi) begin
            m.region = RG_ABOVE;
            m.absorb = !m.from_pci;
        end else if (m.addr < DOS_TOP) begin
            m.region = RG_DOS;
            m.to_dram = 1'b1;
        end else if (m.addr < HOLE_TOP) begin
            m.region = RG_HOLE;
            m.to_dram = !m.hole;
            m.to_pci = m.hole;
        end else if (m.addr < VIDEO_TOP) begin
            m.region = RG_VIDEO;
            // Open lets plain cycles fill the space before first use
            if (!m.from_pci && m.mgmt_en && (m.mgmt || m.mgmt_open)) begin
                m.to_dram = 1'b1;
            end else begin
                m.to_pci = 1'b1;
            end
        end else if (m.addr < MEG) begin
            m.region = (m.addr < EXP_TOP) ? RG_EXP :
                       (m.addr < EXT_TOP) ? RG_EXT : RG_SYS;
            // Shadowed or not, PCI masters are never claimed here
            m.to_dram = en && !m.from_pci;
            m.to_pci = !(en && !m.from_pci);
        end else if (m.addr[31:20] < m.ceil) begin
            m.region = RG_MAIN;
            m.to_dram = 1'b1;
        end else begin
            m.to_pci = 1'b1;
            if (m.addr >= INTC_BASE && m.addr < INTC_TOP) begin
                m.region = RG_INTC;
            end else if (m.addr >= HIBIOS_BASE) begin
                m.region = RG_HIBIOS;
            end else begin
                m.region = RG_PCI;
            end
        end
    end
endmodule

// >>> design/system_address_decoder.sv
// Address decoder of a host-to-PCI bridge: routes host cycles to DRAM,
// PCI or itself, and answers PCI masters whether DRAM claims their cycle.
// Assumes one-cycle request strobes synchronous to clk and a register
// port whose read data is taken in the cycle after the read strobe.
//
// Summary of operation
// - Extended BIOS range is four 16 KB segments with own read/write bits.
// - Top 64 KB segment has read/write bits, both off after reset.
// - A disabled segment is not remapped; its cycles go to PCI.
// - From 1 MB to the DRAM ceiling goes to DRAM, with no hole.
// - Ceiling up to 4 GB goes to PCI, interrupt space included.
// - Interrupt-controller 64 KB holds sixteen 4 KB units, all to PCI when at or above the ceiling.
// - Top 2 MB below 4 GB, the reset fetch area, goes to PCI where at or above the ceiling.
// - Management space off: video range goes to PCI, never DRAM.
// - Management space on: management-mode video cycles go to DRAM.
// - PCI initiators never reach management space in DRAM.
// - Shadowing: write-only sends reads to ROM, writes to DRAM.
// - PCI or ISA masters targeting shadowed segments get no response.
// - Host I/O goes to PCI except the internal port.
// - Configuration address and data ports implement config access.
// - Above 4 GB is claimed: writes dropped, reads return zero.
// - 512-640 KB goes to DRAM unless hole control makes it PCI.
// - Expansion range is eight 16 KB segments, four states each.
`timescale 1ns/1ps
module system_address_decoder
    import addr_map_pkg::*;
#(
    parameter int HOST_AW = 36
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire logic host_valid,
    input wire logic host_io,
    input wire logic host_write,
    input wire logic host_mgmt,
    input wire logic [HOST_AW-1:0] host_addr,
    input wire logic [31:0] host_wdata,
    output logic route_valid,
    output logic route_dram,
    output logic route_pci,
    output logic route_absorb,
    output logic route_internal,
    output logic route_cfg,
    output logic [31:0] host_rdata,
    output logic [31:0] cfg_addr,
    input wire logic pci_valid,
    input wire logic [31:0] pci_addr,
    input wire logic pci_write,
    output logic pci_claim_valid,
    output logic pci_claim
);
    if (HOST_AW < 33) begin : g_check
        $error("HOST_AW must exceed 32");
    end

    map_if hm();
    map_if pm();

    logic [31:0] attr_q, attr_d;
    logic hole_q, hole_d;
    logic [11:0] ceil_q, ceil_d;
    logic mgmt_en_q, mgmt_en_d;
    logic mgmt_open_q, mgmt_open_d;
    logic [31:0] cfg_addr_q, cfg_addr_d;
    logic [31:0] reg_rdata_q, reg_rdata_d;
    region_t region_q, region_d;
    logic [3:0] slot_q, slot_d;
    logic [5:0] route_q, route_d;
    logic [31:0] host_rdata_q, host_rdata_d;
    logic [1:0] claim_q, claim_d;

    // Host request into its decoder
    assign hm.addr = host_addr[31:0];
    assign hm.hi = |host_addr[HOST_AW-1:32];
    assign hm.io = host_io;
    assign hm.write = host_write;
    assign hm.mgmt = host_mgmt;
    assign hm.from_pci = 1'b0;
    assign hm.attr = attr_q;
    assign hm.hole = hole_q;
    assign hm.mgmt_en = mgmt_en_q;
    assign hm.mgmt_open = mgmt_open_q;
    assign hm.cfg_en = cfg_addr_q[CFG_EN_BIT];
    assign hm.ceil = ceil_q;

    // PCI-initiated memory cycles use a second copy of the same map
    assign pm.addr = pci_addr;
    assign pm.hi = 1'b0;
    assign pm.io = 1'b0;
    assign pm.write = pci_write;
    assign pm.mgmt = 1'b0;
    assign pm.from_pci = 1'b1;
    assign pm.attr = attr_q;
    assign pm.hole = hole_q;
    assign pm.mgmt_en = mgmt_en_q;
    assign pm.mgmt_open = mgmt_open_q;
    assign pm.cfg_en = 1'b0;
    assign pm.ceil = ceil_q;

    addr_decode u_host_dec (
        .m(hm)
    );

    addr_decode u_pci_dec (
        .m(pm)
    );

    // Register port and internal configuration address port
    always_comb begin
        attr_d = attr_q;
        hole_d = hole_q;
        ceil_d = ceil_q;
        mgmt_en_d = mgmt_en_q;
        mgmt_open_d = mgmt_open_q;
        cfg_addr_d = cfg_addr_q;
        reg_rdata_d = 32'h0000_0000;
        if (reg_we) begin
            unique case (reg_addr)
                REG_ATTR: attr_d = reg_wdata & ATTR_WMASK;
                REG_HOLE: hole_d = reg_wdata[HOLE_BIT];
                REG_CEIL: ceil_d = reg_wdata[11:0];
                REG_MGMT: begin
                    mgmt_en_d = reg_wdata[MGMT_EN_BIT];
                    mgmt_open_d = reg_wdata[MGMT_OPEN_BIT];
                end
                default: attr_d = attr_q;
            endcase
        end
        if (reg_re) begin
            unique case (reg_addr)
                REG_ATTR: reg_rdata_d = attr_q;
                REG_HOLE: reg_rdata_d = {31'h0000_0000, hole_q};
                REG_CEIL: reg_rdata_d = {20'h0_0000, ceil_q};
                REG_MGMT: reg_rdata_d = {30'h0000_0000, mgmt_open_q, mgmt_en_q};
                REG_LAST: reg_rdata_d = {24'h00_0000, slot_q, region_q};
                default: reg_rdata_d = 32'h0000_0000;
            endcase
        end
        // Handler must restore this across a management entry
        if (host_valid && host_write && hm.internal) begin
            cfg_addr_d = host_wdata & CFG_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            attr_q <= ATTR_RESET;
            hole_q <= 1'b0;
            ceil_q <= CEIL_RESET;
            mgmt_en_q <= 1'b0;
            mgmt_open_q <= 1'b0;
            cfg_addr_q <= 32'h0000_0000;
            reg_rdata_q <= 32'h0000_0000;
        end else begin
            attr_q <= attr_d;
            hole_q <= hole_d;
            ceil_q <= ceil_d;
            mgmt_en_q <= mgmt_en_d;
            mgmt_open_q <= mgmt_open_d;
            cfg_addr_q <= cfg_addr_d;
            reg_rdata_q <= reg_rdata_d;
        end
    end

    // Routing answers, one cycle after each request
    always_comb begin
        route_d = 6'h00;
        host_rdata_d = 32'h0000_0000;
        region_d = region_q;
        slot_d = slot_q;
        claim_d = {pci_valid, pci_valid && pm.to_dram};
        if (host_valid) begin
            route_d = {1'b1, hm.to_dram, hm.to_pci, hm.absorb,
                       hm.internal, hm.cfg};
            region_d = hm.region;
            slot_d = host_addr[15:12];
            // Above 4 GB reads return zero, writes are dropped
            if (hm.internal && !host_write) begin
                host_rdata_d = cfg_addr_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            route_q <= 6'h00;
            host_rdata_q <= 32'h0000_0000;
            region_q <= RG_DOS;
            slot_q <= 4'h0;
            claim_q <= 2'h0;
        end else begin
            route_q <= route_d;
            host_rdata_q <= host_rdata_d;
            region_q <= region_d;
            slot_q <= slot_d;
            claim_q <= claim_d;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign route_valid = route_q[5];
    assign route_dram = route_q[4];
    assign route_pci = route_q[3];
    assign route_absorb = route_q[2];
    assign route_internal = route_q[1];
    assign route_cfg = route_q[0];
    assign host_rdata = host_rdata_q;
    assign cfg_addr = cfg_addr_q;
    assign pci_claim_valid = claim_q[1];
    assign pci_claim = claim_q[0];

    // Checks on routing against the programmed map
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic hmem;
    logic hlow;
    logic [1:0] hsa;
    logic hen;
    assign hmem = host_valid && !host_io && !hm.hi;
    assign hlow = hmem && host_addr[31:20] == 12'h000;
    assign hsa = seg_attr(attr_q, host_addr[31:0]);
    assign hen = host_write ? hsa[ATTR_WR] : hsa[ATTR_RD];

    AST_SEG_SELECT: assert property (
        hlow && host_addr[19:18] == 2'b11 |=> route_dram == $past(hen)
            && route_pci == !$past(hen))
        else $error("segment attribute not honoured");
    AST_EXT_SPLIT: assert property (
        hmem && host_addr[31:16] == 16'h000E && !host_write
            && attr_q[EXT_BASE_BIT + 2 * host_addr[15:14]] |=> route_dram)
        else $error("extended segment read not sent to DRAM");
    AST_SYS_DEFAULT: assert property (
        $past(rst) |-> attr_q[SYS_BASE_BIT +: 2] == 2'b00 && !route_valid)
        else $error("top segment not on PCI after reset");
    AST_MAIN_DRAM: assert property (
        hmem && host_addr[31:20] != 12'h000 && host_addr[31:20] < ceil_q
            |=> route_dram && !route_pci)
        else $error("main memory access not sent to DRAM");
    AST_ABOVE_CEIL: assert property (
        hmem && host_addr[31:20] != 12'h000 && host_addr[31:20] >= ceil_q
            |=> route_pci)
        else $error("access above ceiling not sent to PCI");
    AST_INTC_SLOT: assert property (
        hmem && host_addr[31:16] == INTC_BASE[31:16] && ceil_q <= INTC_BASE[31:20]
            |=> route_pci && region_q == RG_INTC
            && slot_q == $past(host_addr[15:12]))
        else $error("interrupt-controller slot misrouted");
    AST_VIDEO_OFF: assert property (
        hmem && host_addr[31:17] == 15'h0005 && !mgmt_en_q |=> route_pci && !route_dram)
        else $error("video range reached DRAM while disabled");
    AST_MGMT_ON: assert property (
        hmem && host_addr[31:17] == 15'h0005 && mgmt_en_q && host_mgmt |=> route_dram)
        else $error("management cycle not mapped to DRAM");
    AST_PCI_BLOCK: assert property (
        pci_valid && pci_addr[31:20] == 12'h000 && pci_addr >= HOLE_TOP
            |=> pci_claim_valid && !pci_claim)
        else $error("PCI master claimed in protected range");
    AST_IO_PCI: assert property (
        host_valid && host_io && host_addr[15:2] != IO_CFG_ADDR[15:2]
            && host_addr[15:2] != IO_CFG_DATA[15:2] |=> route_pci && !route_internal)
        else $error("host I/O not forwarded to PCI");
    AST_CFG_PORT: assert property (
        host_valid && host_io && host_write && host_addr[15:2] == IO_CFG_ADDR[15:2]
            ##1 !host_valid
            ##1 host_valid && host_io && !host_write
            && host_addr[15:2] == IO_CFG_ADDR[15:2]
            |=> host_rdata == ($past(host_wdata, 3) & CFG_WMASK))
        else $error("config address port readback wrong");
    AST_ABOVE_4G: assert property (
        host_valid && !host_io && hm.hi |=> route_absorb && !route_pci
            && host_rdata == 32'h0000_0000)
        else $error("above 4 GB access not absorbed");
    AST_HOLE: assert property (
        hmem && host_addr[31:17] == 15'h0004 |=> route_pci == $past(hole_q))
        else $error("hole control not honoured");

    AST_ONE_TARGET: assert property (
        route_valid |-> $onehot({route_dram, route_pci,
            route_absorb, route_internal}))
        else $error("route not one-hot");
    AST_ANSWER_NEXT: assert property (
        !$past(rst) |-> route_valid == $past(host_valid)
            && pci_claim_valid == $past(pci_valid))
        else $error("answer out of step");
    AST_PCI_MAIN: assert property (
        pci_valid && pci_addr >= MEG
            && pci_addr[31:20] < ceil_q |=> pci_claim)
        else $error("main memory not claimed");
    AST_HIBIOS: assert property (
        hmem && host_addr[31:21] == 11'h7FF
            && ceil_q <= 12'hFFE |=> route_pci)
        else $error("high BIOS not on PCI");

    COV_SHADOW: cover property (
        hlow && host_write && hsa == 2'b10 ##1 hlow && !host_write && hsa == 2'b01);
    COV_MGMT: cover property (hmem && mgmt_en_q && host_mgmt ##1 route_dram);
    COV_CFG: cover property (route_cfg);
    COV_ABOVE: cover property (route_absorb);
endmodule

// >>> tb/pci_initiator_model.sv
// PCI initiator standing on the far side of the decoder: issues one memory
// cycle per start pulse, after a chosen delay, and reports the claim answer.
// Assumes start is a one-cycle pulse and is not raised again while busy.
`timescale 1ns/1ps
module pci_initiator_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [31:0] start_addr,
    input wire logic start_write,
    input wire logic [3:0] delay,
    output logic pci_valid,
    output logic [31:0] pci_addr,
    output logic pci_write,
    input wire logic pci_claim_valid,
    input wire logic pci_claim,
    output logic done,
    output logic claimed
);
    logic busy_q;
    logic [3:0] cnt_q;
    logic [31:0] addr_q;
    logic write_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            addr_q <= 32'h0000_0000;
            write_q <= 1'b0;
            pci_valid <= 1'b0;
            pci_addr <= 32'h0000_0000;
            pci_write <= 1'b0;
            done <= 1'b0;
            claimed <= 1'b0;
        end else begin
            pci_valid <= 1'b0;
            // Released lines keep toggling so a stale address never looks valid
            pci_addr <= ~pci_addr;
            pci_write <= ~pci_write;
            done <= pci_claim_valid;
            if (pci_claim_valid) begin
                claimed <= pci_claim;
            end
            if (start && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q <= delay;
                addr_q <= start_addr;
                write_q <= start_write;
            end else if (busy_q && cnt_q == 4'h0) begin
                busy_q <= 1'b0;
                pci_valid <= 1'b1;
                pci_addr <= addr_q;
                pci_write <= write_q;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

// >>> tb/tb_system_address_decoder.sv
// Self-checking bench of the address decoder: register port, host routing,
// configuration ports and PCI claims. Assumes the package of the design.
`timescale 1ns/1ps
module tb_system_address_decoder;
    import addr_map_pkg::*;
    localparam logic [4:0] TO_DRAM = 5'h10;
    localparam logic [4:0] TO_PCI = 5'h08;
    localparam logic [4:0] TO_ABSORB = 5'h04;
    localparam logic [4:0] TO_INT = 5'h02;
    localparam logic [4:0] TO_CFG = 5'h09;
    logic clk, rst, reg_we, reg_re, host_valid, host_io, host_write, host_mgmt;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, host_wdata, host_rdata, cfg_addr, pci_addr, p_addr, saved;
    logic [35:0] host_addr, base;
    logic route_valid, route_dram, route_pci, route_absorb, route_internal, route_cfg;
    logic pci_valid, pci_write, pci_claim_valid, pci_claim, p_start, p_write, p_done, p_claimed;
    logic [3:0] p_delay;
    int fail_count, num_checks;

    system_address_decoder #(.HOST_AW(36)) u_system_address_decoder (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .host_valid(host_valid), .host_io(host_io),
        .host_write(host_write), .host_mgmt(host_mgmt), .host_addr(host_addr),
        .host_wdata(host_wdata), .route_valid(route_valid), .route_dram(route_dram),
        .route_pci(route_pci), .route_absorb(route_absorb), .route_internal(route_internal),
        .route_cfg(route_cfg), .host_rdata(host_rdata), .cfg_addr(cfg_addr),
        .pci_valid(pci_valid), .pci_addr(pci_addr), .pci_write(pci_write),
        .pci_claim_valid(pci_claim_valid), .pci_claim(pci_claim));

    pci_initiator_model u_pci_initiator_model (.clk(clk), .rst(rst), .start(p_start),
        .start_addr(p_addr), .start_write(p_write), .delay(p_delay), .pci_valid(pci_valid),
        .pci_addr(pci_addr), .pci_write(pci_write), .pci_claim_valid(pci_claim_valid),
        .pci_claim(pci_claim), .done(p_done), .claimed(p_claimed));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        check(what, {4'h0, exp}, {4'h0, reg_rdata});
    endtask

    // Route flags stand one cycle; they are read just after the answer edge
    task automatic host(input logic io, input logic wr, input logic mg, input logic [35:0] a,
                        input logic [31:0] d, input logic [4:0] exp, input string what);
        @(posedge clk);
        host_valid <= 1'b1;
        host_io <= io;
        host_write <= wr;
        host_mgmt <= mg;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clk);
        host_valid <= 1'b0;
        #1;
        check(what, {30'h0, 1'b1, exp},
              {30'h0, route_valid, route_dram, route_pci, route_absorb, route_internal, route_cfg});
    endtask

    task automatic pci(input logic [31:0] a, input logic [3:0] dly, input logic exp);
        int i;
        @(posedge clk);
        p_start <= 1'b1;
        p_addr <= a;
        p_write <= dly[0];
        p_delay <= dly;
        @(posedge clk);
        p_start <= 1'b0;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (p_done) break;
        end
        if (i == 40) begin
            fail_count++;
            $display("[FAIL] pci claim expected answer seen none");
            results();
        end
        check("pci claim", {35'h0, exp}, {35'h0, p_claimed});
    endtask

    initial begin
        {reg_we, reg_re, host_valid, host_io, host_write, host_mgmt, p_start, p_write} = 8'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        host_addr = 36'h0_0000_0000;
        host_wdata = 32'h0000_0000;
        p_addr = 32'h0000_0000;
        p_delay = 4'h0;
        fail_count = 0;
        num_checks = 0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reg_rd(REG_ATTR, 32'h0000_0000, "attr reset");
        reg_rd(REG_CEIL, 32'h0000_0010, "ceiling reset");
        reg_rd(REG_MGMT, 32'h0000_0000, "mgmt reset");
        reg_wr(8'h20, 32'hFFFF_FFFF);
        reg_rd(8'h20, 32'h0000_0000, "unmapped");
        $display("test registers done");
        host(0, 0, 0, 36'h0_000F_0000, 0, TO_PCI, "bios after reset");
        host(0, 1, 0, 36'h0_0008_0000, 0, TO_DRAM, "dos hole default");
        host(0, 0, 0, 36'h0_000A_0000, 0, TO_PCI, "video");
        host(0, 0, 0, 36'h0_0010_0000, 0, TO_DRAM, "one meg");
        host(0, 0, 0, 36'h0_00FF_FFFC, 0, TO_DRAM, "below ceiling");
        host(0, 1, 0, 36'h0_0100_0000, 0, TO_PCI, "at ceiling");
        host(0, 0, 0, 36'h0_FEC0_F000, 0, TO_PCI, "intc unit f");
        reg_rd(REG_LAST, {24'h00_0000, 4'hF, RG_INTC}, "intc slot");
        host(0, 0, 0, 36'h0_FFE0_0000, 0, TO_PCI, "high bios");
        host(0, 0, 0, 36'h1_0000_0000, 0, TO_ABSORB, "above 4g read");
        check("above 4g data", 36'h0, {4'h0, host_rdata});
        host(0, 1, 0, 36'hF_FFFF_FFFC, 0, TO_ABSORB, "above 4g write");
        host(1, 0, 0, 36'h0_0000_0080, 0, TO_PCI, "plain io");
        $display("test default map done");
        // Bit pair of segment k sits at 2k in all three groups
        for (int k = 0; k < 13; k++) begin
            base = (k < 8) ? 36'h0_000C_0000 + 36'(k) * 36'h4000 :
                   (k < 12) ? 36'h0_000E_0000 + 36'(k - 8) * 36'h4000 : 36'h0_000F_0000;
            for (int s = 0; s < 4; s++) begin
                reg_wr(REG_ATTR, 32'(s) << (2 * k));
                host(0, 0, 0, base + 36'h3FFC, 0, s[0] ? TO_DRAM : TO_PCI, "seg read");
                host(0, 1, 0, base, 0, s[1] ? TO_DRAM : TO_PCI, "seg write");
                if (s == 3) begin
                    host(0, 0, 0, base + 36'h4000, 0, (k == 12) ? TO_DRAM : TO_PCI, "next seg");
                end
            end
        end
        reg_wr(REG_ATTR, 32'hFFFF_FFFF);
        reg_rd(REG_ATTR, ATTR_WMASK, "attr mask");
        pci(32'h000F_0000, 4'h0, 1'b0);
        pci(32'h000C_4000, 4'h5, 1'b0);
        pci(32'h0020_0000, 4'h3, 1'b1);
        pci(32'h0100_0000, 4'h0, 1'b0);
        $display("test segments done");
        reg_wr(REG_HOLE, 32'h0000_0001);
        reg_rd(REG_HOLE, 32'h0000_0001, "hole reg");
        host(0, 0, 0, 36'h0_0009_FFFC, 0, TO_PCI, "hole on");
        host(0, 0, 0, 36'h0_0007_FFFC, 0, TO_DRAM, "below hole");
        pci(32'h0008_0000, 4'h1, 1'b0);
        reg_wr(REG_CEIL, 32'h0000_0020);
        reg_rd(REG_CEIL, 32'h0000_0020, "ceiling reg");
        host(0, 1, 0, 36'h0_01FF_FFFC, 0, TO_DRAM, "new ceiling below");
        host(0, 0, 0, 36'h0_0200_0000, 0, TO_PCI, "new ceiling at");
        $display("test hole and ceiling done");
        reg_wr(REG_MGMT, 32'h0000_0003);
        host(0, 1, 0, 36'h0_000A_0000, 0, TO_DRAM, "mgmt fill");
        reg_wr(REG_MGMT, 32'h0000_0001);
        reg_rd(REG_MGMT, 32'h0000_0001, "mgmt reg");
        host(0, 0, 1, 36'h0_000A_0000, 0, TO_DRAM, "mgmt cycle");
        host(0, 0, 0, 36'h0_000B_FFFC, 0, TO_PCI, "plain video");
        pci(32'h000A_0000, 4'h0, 1'b0);
        reg_wr(REG_MGMT, 32'h0000_0000);
        host(0, 0, 1, 36'h0_000A_0000, 0, TO_PCI, "mgmt off");
        $display("test management done");
        host(1, 1, 0, 36'h0_0000_0CF8, 32'hFFFF_FFFF, TO_INT, "cfg addr write");
        check("cfg addr", {4'h0, CFG_WMASK}, {4'h0, cfg_addr});
        host(1, 0, 0, 36'h0_0000_0CF8, 0, TO_INT, "cfg addr read");
        check("cfg addr data", {4'h0, CFG_WMASK}, {4'h0, host_rdata});
        saved = host_rdata;
        host(1, 0, 0, 36'h0_0000_0CFC, 0, TO_CFG, "cfg data");
        host(1, 1, 1, 36'h0_0000_0CF8, 32'h0000_0000, TO_INT, "handler write");
        host(1, 0, 1, 36'h0_0000_0CFC, 0, TO_PCI, "cfg disabled");
        host(1, 1, 1, 36'h0_0000_0CF8, saved, TO_INT, "handler restore");
        host(1, 1, 0, 36'h0_0000_0CFC, 0, TO_CFG, "cfg after restore");
        $display("test config ports done");
        results();
    end
endmodule
